// [rtl/front_panel_menu_controller.sv]
`timescale 1ns/1ps
`include "panel_map.svh"

module front_panel_menu_controller #(
  parameter int TICK_CYCLES = `FP_TICK_CYCLES   // cycles per 10 ms tick
) (
  input  wire logic        I_CLOCK,            // 20 MHz module clock
  input  wire logic        I_RESET_N,          // power-on reset, active low
  input  wire logic        I_STEP_BUTTON,      // reset/step button pin
  input  wire logic        I_PROGRAM_BUTTON,   // program button pin
  input  wire logic        I_BLOCK_INPUT_ONE,  // external stack select pin
  input  wire logic        I_OPERATION,        // operation event pulse
  input  wire logic [3:0]  I_OPERATION_CODE,   // code shown on operation
  input  wire logic [3:0]  I_RECORD_REG,       // recorded register number
  input  wire logic [11:0] I_RECORD_VALUE,     // recorded value, bcd
  input  wire logic [7:0]  I_ADDR,             // register address
  input  wire logic [31:0] I_WDATA,            // register write data
  input  wire logic        I_WR,               // write strobe
  input  wire logic        I_RD,               // read strobe
  output logic      [31:0] O_RDATA,            // read data, cycle after strobe
  output logic      [31:0] O_SEGMENTS,         // red,left,mid,right {dp,g..a}
  output logic      [4:0]  O_INDICATOR_LED,    // value and switchgroup leds
  output logic             O_ACTIVE_STACK,     // 0 main, 1 second stack
  output logic      [7:0]  O_SWITCHGROUP,      // active switchgroup
  output logic             O_TEST_ACTIVE       // display test running
);
  import panel_pkg::*;

  localparam int BACK_T  = `FP_MS2TICK(`FP_BACK_MIN_MS);
  localparam int FWD_T   = `FP_MS2TICK(`FP_FWD_MS);
  localparam int HOLD_T  = `FP_MS2TICK(`FP_HOLD_MS);
  localparam int PAUSE_T = `FP_MS2TICK(`FP_PAUSE_MS);
  localparam int IDLE_T  = `FP_MS2TICK(`FP_IDLE_MS);
  localparam int STEP_T  = `FP_MS2TICK(`FP_TEST_MS) / `FP_TEST_STEPS + 1;
  localparam int CONF_T  = `FP_MS2TICK(`FP_CONFIRM_MS);
  localparam int BLINK_T = `FP_MS2TICK(`FP_BLINK_MS);

  state_t st_q;
  state_t st_d;

  function automatic logic [6:0] seg7(input logic [3:0] v);
    case (v)
      4'h0:    seg7 = 7'h3f;
      4'h1:    seg7 = 7'h06;
      4'h2:    seg7 = 7'h5b;
      4'h3:    seg7 = 7'h4f;
      4'h4:    seg7 = 7'h66;
      4'h5:    seg7 = 7'h6d;
      4'h6:    seg7 = 7'h7d;
      4'h7:    seg7 = 7'h07;
      4'h8:    seg7 = 7'h7f;
      4'h9:    seg7 = 7'h6f;
      default: seg7 = 7'h00;
    endcase
  endfunction

  // three green digits with the decimal point on the digit it names
  function automatic logic [23:0] green(input logic [13:0] v);
    green = '0;
    for (int k = 0; k < 3; k++) begin
      green[8*k +: 8] = {v[13:12] == 2'(k), seg7(v[4*k +: 4])};
    end
  endfunction

  // weighted sum of the switches, 1 for switch one up to 128
  function automatic logic [11:0] bcd3(input logic [7:0] v);
    bcd3 = {4'(v / 8'd100), 4'((v % 8'd100) / 8'd10), 4'(v % 8'd10)};
  endfunction

  // last submenu position of a main menu item, zero if none
  function automatic logic [1:0] sub_last(input logic [2:0] it);
    if (it != `FP_ITEM_DARK && it <= `FP_ITEM_SWGRP) begin
      sub_last = 2'h2;
    end else if (it == `FP_ITEM_STACK) begin
      sub_last = 2'h1;
    end else begin
      sub_last = 2'h0;
    end
  endfunction

  // next state of the whole panel
  always_comb begin
    logic        tick;
    logic [1:0]  press;
    logic [1:0]  rel;
    logic        free;
    logic        both_ev;
    logic        fwd;
    logic        back;
    logic        dark;
    logic        ok;
    logic        tgt;
    logic [1:0]  vi;
    logic [13:0] shown;
    logic [7:0]  red;
    logic [23:0] grn;
    logic [4:0]  s;
    tick    = 1'b0;
    press   = '0;
    rel     = '0;
    free    = 1'b0;
    both_ev = 1'b0;
    fwd     = 1'b0;
    back    = 1'b0;
    ok      = 1'b0;
    red     = '0;
    grn     = '0;
    s       = '0;
    dark    = 1'b0;
    tgt     = 1'b0;
    vi      = '0;
    shown   = '0;
    st_d    = st_q;

    // slow timebase; press lengths are counted in ticks
    tick = (st_q.tick_cnt == 18'(TICK_CYCLES - 1));
    st_d.tick_cnt = tick ? 18'h0 : st_q.tick_cnt + 18'h1;

    // pins pass three flops; buttons sampled per tick to ride out bounce
    st_d.sync1 = {I_BLOCK_INPUT_ONE, I_PROGRAM_BUTTON, I_STEP_BUTTON};
    st_d.sync2 = st_q.sync1;
    st_d.sync3 = st_q.sync2;
    for (int i = 0; i < 2; i++) begin
      if (tick && st_q.sync2[i] == st_q.sync3[i]) st_d.btn[i] = st_q.sync3[i];
    end
    if (st_q.sync2[2] == st_q.sync3[2]) st_d.ext = st_q.sync3[2];
    press = st_d.btn & ~st_q.btn;
    rel   = st_q.btn & ~st_d.btn;

    // flash phase shared by every flashing digit
    if (tick) begin
      st_d.blink_cnt = st_q.blink_cnt + 5'h1;
      if (st_q.blink_cnt == 5'(BLINK_T - 1)) begin
        st_d.blink_cnt = '0;
        st_d.blink     = ~st_q.blink;
      end
    end

    // stack selection: external level change, then serial command
    if (st_d.ext != st_q.ext) st_d.stack = st_d.ext;
    if (I_WR && I_ADDR == `FP_REG_STACK_CMD) st_d.stack = I_WDATA[0];
    if (I_WR && I_ADDR == `FP_REG_LIMIT) st_d.limit = I_WDATA[11:0];

    // latched operation indicator; a new event beats the clearing press
    if (press[0]) st_d.op_on = 1'b0;
    if (I_OPERATION) begin
      st_d.op_on   = 1'b1;
      st_d.op_code = I_OPERATION_CODE;
    end

    // press lengths, saturating so a long hold cannot wrap
    if (tick && st_q.btn[0] && st_q.step_len != 8'hff) st_d.step_len = st_q.step_len + 8'h1;
    if (tick && st_q.btn[1] && st_q.prog_len != 9'(HOLD_T)) begin
      st_d.prog_len = st_q.prog_len + 9'h1;
    end

    // both buttons: one event, then every single action but the indicator-clearing and test-aborting step press is muted until release
    if (st_d.btn == 2'b11 && !st_q.both_lock) begin
      st_d.both_lock = 1'b1;
      both_ev        = 1'b1;
    end
    if (st_d.btn == 2'b00) st_d.both_lock = 1'b0;
    free = !st_q.both_lock && !both_ev;

    // inactivity counter; the dark idle position needs no timeout
    dark = (st_q.item == `FP_ITEM_DARK) && (st_q.sub == 2'h0);
    if (press != 2'b00) begin
      st_d.idle_cnt = '0;
    end else if (tick && st_q.mode != M_TEST && !(st_q.mode == M_MENU && dark)) begin
      st_d.idle_cnt = st_q.idle_cnt + 15'h1;
    end

    tgt = (st_q.sub == 2'h0) ? st_q.stack : st_q.sub[1];
    vi  = 2'(st_q.item - 3'h1);

    case (st_q.mode)
      // protection keeps running; nothing here gates it
      M_TEST: begin
        if (tick) begin
          st_d.test_cnt = st_q.test_cnt + 7'h1;
          if (st_q.test_cnt == 7'(STEP_T - 1)) begin
            st_d.test_cnt  = '0;
            st_d.test_step = st_q.test_step + 5'h1;
            if (st_q.test_step == 5'(`FP_TEST_STEPS - 1)) st_d.mode = M_MENU;
          end
        end
        if (press[0]) st_d.mode = M_MENU;
      end
      M_MENU: begin
        // forward fires while held; a repeat at dark waits longer
        if (free && tick && st_q.btn[0] && st_q.step_len ==
            8'(((dark && st_q.step_fwd) ? PAUSE_T : FWD_T) - 1)) begin
          fwd           = 1'b1;
          st_d.step_len = '0;
          st_d.step_fwd = 1'b1;
        end
        if (free && rel[0] && !st_q.step_fwd && st_q.step_len >= 8'(BACK_T) && !dark) begin
          back = 1'b1;
        end
        if (fwd) begin
          if (st_q.sub != 2'h0) begin
            st_d.sub = (st_q.sub == sub_last(st_q.item)) ? 2'h0 : st_q.sub + 2'h1;
          end else begin
            st_d.item = st_q.item + 3'h1;
          end
        end
        if (back) begin
          if (st_q.sub != 2'h0) st_d.sub = st_q.sub - 2'h1;
          else st_d.item = st_q.item - 3'h1;
        end
        // long program hold opens setting mode on the current value
        if (free && tick && st_q.btn[1] && st_q.prog_len == 9'(HOLD_T - 1) &&
            sub_last(st_q.item) != 2'h0) begin
          st_d.mode      = M_SET;
          st_d.cursor    = '0;
          st_d.edit_val  = st_q.item == `FP_ITEM_STACK ? {`FP_DP_NONE, 11'h0, st_q.stack} :
                           st_q.val[tgt][vi];
          st_d.edit_sw   = st_q.sg[tgt];
          st_d.prog_done = 1'b1;
        end
        if (free && rel[1] && !st_q.prog_done && st_q.prog_len >= 9'(FWD_T) &&
            st_q.sub == 2'h0 && sub_last(st_q.item) != 2'h0) begin
          st_d.sub = 2'h1;
        end
      end
      M_SET: begin
        if (free && tick && st_q.btn[1] && st_q.prog_len == 9'(HOLD_T - 1)) begin
          st_d.mode      = M_MENU;
          st_d.prog_done = 1'b1;
        end
        if (free && rel[1] && !st_q.prog_done) begin
          st_d.cursor = (st_q.cursor == (st_q.item == `FP_ITEM_SWGRP ? 4'h8 : 4'h4)) ?
                        4'h0 : st_q.cursor + 4'h1;
        end
        if (free && rel[0] && st_q.cursor != 4'h0) begin
          if (st_q.item == `FP_ITEM_SWGRP) begin
            st_d.edit_sw[3'(st_q.cursor - 4'h1)] = ~st_q.edit_sw[3'(st_q.cursor - 4'h1)];
          end else if (st_q.cursor == 4'h4) begin
            st_d.edit_val[13:12] = st_q.edit_val[13:12] + 2'h1;
          end else begin
            for (int k = 0; k < 3; k++) begin
              if (st_q.cursor == 4'(k + 1)) begin
                st_d.edit_val[4*k +: 4] = (st_q.edit_val[4*k +: 4] >= 4'h9) ?
                                          4'h0 : st_q.edit_val[4*k +: 4] + 4'h1;
              end
            end
          end
        end
        if (both_ev) begin
          if (st_q.item == `FP_ITEM_SWGRP) begin
            ok = 1'b1;
            st_d.sg[tgt] = st_q.edit_sw;
          end else if (st_q.item == `FP_ITEM_STACK) begin
            ok = st_q.edit_val[11:0] <= 12'h001;
            if (ok) st_d.stack = st_q.edit_val[0];
          end else begin
            ok = st_q.edit_val[11:0] != 12'h000 && st_q.edit_val[11:0] <= st_q.limit;
            if (ok) st_d.val[tgt][vi] = st_q.edit_val;
          end
          st_d.mode     = ok ? M_CONFIRM : M_MENU;
          st_d.conf_cnt = '0;
        end
      end
      M_CONFIRM: begin
        if (tick) begin
          st_d.conf_cnt = st_q.conf_cnt + 7'h1;
          if (st_q.conf_cnt == 7'(CONF_T - 1)) st_d.mode = M_MENU;
        end
      end
      default: st_d.mode = M_MENU;
    endcase

    // a release ends the measurement of that button
    if (rel[0]) begin
      st_d.step_len = '0;
      st_d.step_fwd = 1'b0;
    end
    if (rel[1]) begin
      st_d.prog_len  = '0;
      st_d.prog_done = 1'b0;
    end

    // untouched for five minutes: back to the dark normal state
    if (st_q.idle_cnt >= 15'(IDLE_T)) begin
      st_d.mode     = M_MENU;
      st_d.item     = `FP_ITEM_DARK;
      st_d.sub      = 2'h0;
      st_d.idle_cnt = '0;
    end

    // value on the green digits in the menus
    if (st_q.item == `FP_ITEM_RECORD) begin
      shown = {`FP_DP_NONE, I_RECORD_VALUE};
    end else if (st_q.item == `FP_ITEM_SWGRP) begin
      shown = {`FP_DP_NONE, bcd3(st_q.sg[tgt])};
    end else if (st_q.item == `FP_ITEM_STACK) begin
      shown = {`FP_DP_NONE, 11'h0, st_q.stack};
    end else begin
      shown = st_q.val[tgt][vi];
    end
    if (st_q.item == `FP_ITEM_RECORD) red = {1'b0, seg7(I_RECORD_REG)};
    else if (st_q.sub == 2'h0) red = {1'b0, seg7({1'b0, st_q.item})};
    else red = {1'b0, seg7({2'h0, st_q.sub})};

    // display image; registered so the segment pins never glitch
    st_d.seg = '0;
    case (st_q.mode)
      M_TEST: begin
        s = (st_q.test_step < 5'(`FP_TEST_PASS)) ? st_q.test_step :
            st_q.test_step - 5'(`FP_TEST_PASS);
        if (s < 5'h6) st_d.seg = {4{8'(8'h01 << s)}};
        else if (s == 5'h6) st_d.seg = {4{8'h80}};
        for (int k = 0; k < 4; k++) begin
          if (s == 5'(10 - k)) st_d.seg[8*k +: 8] = 8'h40;
        end
      end
      M_MENU: begin
        if (dark) begin
          if (st_q.op_on) st_d.seg[31:24] = {1'b0, seg7(st_q.op_code)};
        end else begin
          if (st_q.sub != 2'h0 && st_q.blink) red = '0;
          st_d.seg = {red, green(shown)};
        end
      end
      M_SET: begin
        if (st_q.item == `FP_ITEM_SWGRP && st_q.cursor != 4'h0) begin
          red = {1'b0, seg7(st_q.cursor)};
          grn = {16'h0, 1'b0, seg7({3'h0, st_q.edit_sw[3'(st_q.cursor - 4'h1)]})};
          if (st_q.blink) grn = '0;
        end else begin
          grn = green(st_q.item == `FP_ITEM_SWGRP ? {`FP_DP_NONE, bcd3(st_q.edit_sw)} :
                      st_q.edit_val);
          if (st_q.blink && st_q.cursor == 4'h4) grn = grn & 24'h7f7f7f;
          for (int k = 0; k < 3; k++) begin
            if (st_q.blink && st_q.cursor == 4'(k + 1)) grn[8*k +: 8] = 8'h00;
          end
        end
        st_d.seg = {red, grn};
        if (st_q.blink && st_q.cursor == 4'h0) st_d.seg = '0;
      end
      M_CONFIRM: st_d.seg = {red, 24'h404040};
      default:   st_d.seg = '0;
    endcase

    // indicator of the value or switchgroup on show, kept in submenus
    st_d.led = '0;
    // value items only; the switchgroup has its own lamp and must not light a value one
    if (st_q.mode != M_TEST && st_q.item != `FP_ITEM_DARK && st_q.item < `FP_ITEM_SWGRP) begin
      st_d.led[vi + 3'h0] = 1'b1;
    end
    if (st_q.mode != M_TEST && st_q.item == `FP_ITEM_SWGRP) st_d.led[4] = 1'b1;

    // register read; data stand only in the cycle after the strobe
    st_d.rdata = '0;
    if (I_RD) begin
      case (I_ADDR)
        `FP_REG_STACK_CMD: st_d.rdata = {31'h0, st_q.stack};
        `FP_REG_LIMIT:     st_d.rdata = {20'h0, st_q.limit};
        `FP_REG_STATUS:    st_d.rdata = {18'h0, st_q.mode == M_TEST, st_q.op_on, st_q.stack,
                                         st_q.mode, st_q.cursor, st_q.sub, st_q.item};
        `FP_REG_SWGRP:     st_d.rdata = {24'h0, st_q.sg[st_q.stack]};
        default:           st_d.rdata = '0;
      endcase
    end
  end

  // single state register; stored settings are lost on power loss here
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      st_q       <= '0;
      st_q.limit <= `FP_LIMIT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign O_RDATA         = st_q.rdata;
  assign O_SEGMENTS      = st_q.seg;
  assign O_INDICATOR_LED = st_q.led;
  assign O_ACTIVE_STACK  = st_q.stack;
  assign O_SWITCHGROUP   = st_q.sg[st_q.stack];
  assign O_TEST_ACTIVE   = (st_q.mode == M_TEST);

endmodule // front_panel_menu_controller

// [rtl/panel_map.svh]
`ifndef PANEL_MAP_SVH
`define PANEL_MAP_SVH

// timebase
`define FP_CLK_NS           50
`define FP_TICK_MS          10
`define FP_TICK_CYCLES      (`FP_TICK_MS * 1000000 / `FP_CLK_NS)
`define FP_MS2TICK(ms)      (((ms) + `FP_TICK_MS - 1) / `FP_TICK_MS)

// press and display timing in milliseconds; test steps and passes as counts
`define FP_BACK_MIN_MS      250
`define FP_FWD_MS           1000
`define FP_HOLD_MS          5000
`define FP_PAUSE_MS         2000
`define FP_IDLE_MS          300000
`define FP_TEST_MS          15000
`define FP_TEST_STEPS       22
`define FP_TEST_PASS        11
`define FP_CONFIRM_MS       1000
`define FP_BLINK_MS         250

// register offsets
`define FP_REG_STACK_CMD    8'h00
`define FP_REG_LIMIT        8'h04
`define FP_REG_STATUS       8'h08
`define FP_REG_SWGRP        8'h0c

// reset values
`define FP_LIMIT_RST        12'h999

// menu positions and the no-decimal-point code
`define FP_ITEM_DARK        3'h0
`define FP_ITEM_SWGRP       3'h5
`define FP_ITEM_RECORD      3'h6
`define FP_ITEM_STACK       3'h7
`define FP_DP_NONE          2'h3

`endif

// [rtl/panel_pkg.sv]
package panel_pkg;

  typedef enum logic [1:0] {M_TEST, M_MENU, M_SET, M_CONFIRM} mode_t;

  typedef struct packed {
    logic [2:0]             sync1;
    logic [2:0]             sync2;
    logic [2:0]             sync3;
    logic [1:0]             btn;
    logic                   ext;
    logic [17:0]            tick_cnt;
    logic [4:0]             blink_cnt;
    logic                   blink;
    mode_t                  mode;
    logic [4:0]             test_step;
    logic [6:0]             test_cnt;
    logic [2:0]             item;
    logic [1:0]             sub;
    logic [7:0]             step_len;
    logic                   step_fwd;
    logic [8:0]             prog_len;
    logic                   prog_done;
    logic                   both_lock;
    logic [3:0]             cursor;
    logic [13:0]            edit_val;
    logic [7:0]             edit_sw;
    logic [1:0][3:0][13:0]  val;
    logic [1:0][7:0]        sg;
    logic                   stack;
    logic [11:0]            limit;
    logic                   op_on;
    logic [3:0]             op_code;
    logic [14:0]            idle_cnt;
    logic [6:0]             conf_cnt;
    logic [31:0]            seg;
    logic [4:0]             led;
    logic [31:0]            rdata;
  } state_t;

endpackage

// [test/front_panel_menu_controller_tb_top.sv]
`timescale 1ns/1ps
module front_panel_menu_controller_tb_top;
  localparam int TK = 4;  // short tick keeps the run small
  logic        clk = 1'b0, rst_n = 1'b0, ext = 1'b0, op = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0]  opc = 4'h0, rreg = 4'h0;
  logic [11:0] rval = 12'h0;
  logic [7:0]  addr = 8'h0, sgrp, pat;
  logic [31:0] wdata = 32'h0, rdat, seg, st, d32, seg2;
  logic [4:0]  led, led2;
  logic        rst2_n = 1'b0, stp2 = 1'b0, idle_done = 1'b0;
  logic        stk, tst, on, off;
  wire         step, prog;
  int          bad_count = 0, check_count = 0, seed = 60, d;
  logic [7:0]  sev [10] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07, 8'h7f, 8'h6f};

  always #25 clk = ~clk;

  front_panel_menu_controller #(.TICK_CYCLES(TK)) dut (
    .I_CLOCK(clk), .I_RESET_N(rst_n), .I_STEP_BUTTON(step), .I_PROGRAM_BUTTON(prog),
    .I_BLOCK_INPUT_ONE(ext), .I_OPERATION(op), .I_OPERATION_CODE(opc),
    .I_RECORD_REG(rreg), .I_RECORD_VALUE(rval), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdat), .O_SEGMENTS(seg), .O_INDICATOR_LED(led),
    .O_ACTIVE_STACK(stk), .O_SWITCHGROUP(sgrp), .O_TEST_ACTIVE(tst));
  panel_operator #(.TICK(TK)) opr (.i_clk(clk), .o_step(step), .o_prog(prog));
  // second unit on a one-cycle tick so the idle limit fits inside the run
  front_panel_menu_controller #(.TICK_CYCLES(1)) dut2 (
    .I_CLOCK(clk), .I_RESET_N(rst2_n), .I_STEP_BUTTON(stp2), .I_PROGRAM_BUTTON(1'b0),
    .I_BLOCK_INPUT_ONE(1'b0), .I_OPERATION(1'b0), .I_OPERATION_CODE(4'h0),
    .I_RECORD_REG(4'h0), .I_RECORD_VALUE(12'h0), .I_ADDR(8'h0), .I_WDATA(32'h0),
    .I_WR(1'b0), .I_RD(1'b0), .O_RDATA(), .O_SEGMENTS(seg2), .O_INDICATOR_LED(led2),
    .O_ACTIVE_STACK(), .O_SWITCHGROUP(), .O_TEST_ACTIVE());

  function automatic int rnd10();
    return ($random(seed) & 32'h7fffffff) % 10;
  endfunction
  // weighted sum, switch k carries weight 2**(k-1)
  function automatic logic [7:0] csum(input logic [7:0] p);
    int s;
    s = 0;
    for (int k = 0; k < 8; k++) s += p[k] << k;
    return s[7:0];
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk) begin
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
    end
    @(posedge clk) wr <= 1'b0;
  endtask
  // write then read with no gap between the two strobes
  task automatic wrrd(input logic [7:0] a, input logic [31:0] v, input logic [7:0] ra,
                      output logic [31:0] r);
    @(posedge clk) begin
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
    end
    @(posedge clk) begin
      wr <= 1'b0;
      addr <= ra;
      rd <= 1'b1;
    end
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) r = rdat;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk) begin
      addr <= a;
      rd <= 1'b1;
    end
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) v = rdat;
  endtask
  task automatic stat();
    rdreg(8'h08, st);
  endtask
  task automatic fwd();
    opr.push(1'b1, 1'b0, 110);
  endtask
  task automatic back();
    opr.push(1'b1, 1'b0, 50);
  endtask
  task automatic tap(input logic s, input logic p);
    opr.push(s, p, 30);
  endtask
  task automatic hold_prog();
    opr.push(1'b0, 1'b1, 510);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // watchdog sized well above the expected run of about 32000 cycles
  initial begin
    #4000000;
    bad_count++;
    wrap_up();
  end

  // idle unit: abort its test, step once, then leave it untouched
  initial begin
    repeat (8) @(posedge clk);
    rst2_n <= 1'b1;
    repeat (20) @(posedge clk);
    stp2 <= 1'b1;
    repeat (110) @(posedge clk);
    stp2 <= 1'b0;
    repeat (20) @(posedge clk);
    chk(led2, 5'h01);
    repeat (29370) @(posedge clk);
    chk(seg2[31:24], 8'h06);
    repeat (1000) @(posedge clk);
    chk(seg2, 32'h0);
    chk(led2, 5'h00);
    idle_done = 1'b1;
  end

  initial begin
    rreg = 4'(rnd10());
    rval = 12'h123;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(seg, 32'h01010101);
    rdreg(8'h04, d32); chk(d32, 32'h999);
    rdreg(8'h00, d32); chk(d32, 32'h0);
    rdreg(8'h10, d32); chk(d32, 32'h0);
    stat(); chk(st[13:9], 5'h10);
    repeat (1495 * TK) @(posedge clk);
    chk(tst, 1'b1);
    repeat (40 * TK) @(posedge clk);
    chk(seg, 32'h0);
    chk(tst, 1'b0);
    $display("power-up test done");
    // second reset in mid-run, then abort the test with a step press
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (100 * TK) @(posedge clk);
    tap(1'b1, 1'b0);
    chk(seg, 32'h0);
    chk(tst, 1'b0);
    $display("abort done");
    fwd(); stat(); chk(st[2:0], 3'h1);
    chk(led, 5'h01);
    chk(seg[31:24], 8'h06);
    back(); stat(); chk(st[2:0], 3'h0);
    back(); stat(); chk(st[2:0], 3'h0);
    fwd(); fwd(); back(); stat(); chk(st[2:0], 3'h1);
    $display("stepping done");
    opr.push(1'b0, 1'b1, 150); stat(); chk(st[4:3], 2'h1);
    chk(led, 5'h01);
    on = 1'b0;
    off = 1'b0;
    repeat (60 * TK) begin
      @(negedge clk);
      if (seg[31:24] === 8'h06) on = 1'b1;
      if (seg[31:24] === 8'h00) off = 1'b1;
    end
    chk({on, off}, 2'b11);
    fwd(); stat(); chk(st[4:3], 2'h2);
    back(); back(); stat(); chk(st[4:3], 2'h0);
    $display("submenu done");
    // edit the units digit by a random count and commit
    opr.push(1'b0, 1'b1, 150);
    d = rnd10() % 9 + 1;
    hold_prog(); stat(); chk(st[10:9], 2'h2);
    tap(1'b0, 1'b1); stat(); chk(st[8:5], 4'h1);
    repeat (d) tap(1'b1, 1'b0);
    tap(1'b1, 1'b1); stat(); chk(st[10:9], 2'h3);
    chk(seg[23:0], 24'h404040);
    repeat (100 * TK) @(posedge clk);
    stat(); chk(st[10:9], 2'h1);
    chk(st[4:3], 2'h1);
    chk(seg[6:0], sev[d][6:0]);
    // edit again but leave with a long hold
    hold_prog(); tap(1'b0, 1'b1); tap(1'b1, 1'b0);
    hold_prog(); stat(); chk(st[10:9], 2'h1);
    chk(seg[6:0], sev[d][6:0]);
    // limit of one makes any edited value from two upward illegal
    wreg(8'h04, 32'h1); rdreg(8'h04, d32); chk(d32, 32'h1);
    hold_prog(); tap(1'b0, 1'b1); tap(1'b1, 1'b0);
    tap(1'b1, 1'b1); stat(); chk(st[10:9], 2'h1);
    chk(seg[6:0], sev[d][6:0]);
    wreg(8'h04, 32'h999);
    $display("setting done");
    back(); fwd(); fwd(); fwd(); fwd();
    stat(); chk(st[2:0], 3'h5);
    chk(led, 5'h10);
    opr.push(1'b0, 1'b1, 150);
    hold_prog();
    pat = $random(seed);
    for (int k = 0; k < 8; k++) begin
      tap(1'b0, 1'b1);
      if (pat[k]) tap(1'b1, 1'b0);
    end
    tap(1'b0, 1'b1);
    tap(1'b1, 1'b1);
    repeat (100 * TK) @(posedge clk);
    chk(sgrp, csum(pat));
    rdreg(8'h0c, d32); chk(d32, {24'h0, csum(pat)});
    $display("switchgroup done");
    wrrd(8'h00, 32'h1, 8'h08, st); chk(st[11], 1'b1);
    chk(stk, 1'b1);
    chk(sgrp, 8'h00);
    ext <= 1'b1;
    repeat (5 * TK) @(posedge clk);
    ext <= 1'b0;
    repeat (5 * TK) @(posedge clk);
    chk(stk, 1'b0);
    chk(sgrp, csum(pat));
    $display("stack done");
    back(); fwd(); chk(seg[31:24], sev[rreg]);
    fwd(); fwd();
    opc <= 4'(rnd10());
    op <= 1'b1;
    @(posedge clk) op <= 1'b0;
    repeat (5) @(posedge clk);
    chk(seg, {sev[opc], 24'h0});
    stat(); chk(st[12], 1'b1);
    tap(1'b1, 1'b0); stat(); chk(st[12], 1'b0);
    $display("operation done");
    wait (idle_done);
    wrap_up();
  end
endmodule // front_panel_menu_controller_tb_top

// [test/panel_operator.sv]
`timescale 1ns/1ps
module panel_operator #(
  parameter int TICK = 4  // clock cycles per press-timing tick
) (
  input  wire logic i_clk,   // bench clock
  output logic      o_step,  // step button, high pressed
  output logic      o_prog   // program button, high pressed
);
  initial begin
    o_step = 1'b0;
    o_prog = 1'b0;
  end
  // hold for t ticks, then a quiet gap so the release is seen before the next press
  task automatic push(input logic s, input logic p, input int t);
    @(posedge i_clk) begin
      o_step <= s;
      o_prog <= p;
    end
    repeat (t * TICK) @(posedge i_clk);
    o_step <= 1'b0;
    o_prog <= 1'b0;
    repeat (12 * TICK) @(posedge i_clk);
  endtask
endmodule // panel_operator

// [test/panel_properties.sv]
`timescale 1ns/1ps
module panel_properties (
  input wire logic        I_CLOCK,           // clock
  input wire logic        I_RESET_N,         // reset, active low
  input wire logic [7:0]  I_ADDR,            // address
  input wire logic [31:0] I_WDATA,           // write data
  input wire logic        I_WR,              // write strobe
  input wire logic        I_RD,              // read strobe
  input wire logic [31:0] O_RDATA,           // read data
  input wire logic [31:0] O_SEGMENTS,        // segments
  input wire logic [4:0]  O_INDICATOR_LED,   // leds
  input wire logic        O_ACTIVE_STACK,    // stack
  input wire logic [7:0]  O_SWITCHGROUP,     // switchgroup
  input wire logic        O_TEST_ACTIVE      // test running
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);
  sequence s_wr_stack; I_WR && I_ADDR == 8'h00; endsequence
  sequence s_rd_status; I_RD && I_ADDR == 8'h08; endsequence
  property p_stack_wr; s_wr_stack |=> O_ACTIVE_STACK == $past(I_WDATA[0]); endproperty
  a_stack_wr: assert property (p_stack_wr) else $error("stack write lost");
  property p_stack_rd;
    s_wr_stack ##1 s_rd_status |=> O_RDATA[11] == $past(I_WDATA[0], 2);
  endproperty
  a_stack_rd: assert property (p_stack_rd) else $error("stack readback wrong");
  property p_status;
    s_rd_status |=> O_RDATA[13] == $past(O_TEST_ACTIVE) && O_RDATA[11] == $past(O_ACTIVE_STACK);
  endproperty
  a_status: assert property (p_status) else $error("status word wrong");
  property p_swgrp;
    I_RD && I_ADDR == 8'h0c |=> O_RDATA == {24'h0, $past(O_SWITCHGROUP)};
  endproperty
  a_swgrp: assert property (p_swgrp) else $error("switchgroup read wrong");
  // the test runs once per reset; it may never restart on its own
  property p_test_once; !O_TEST_ACTIVE |=> !O_TEST_ACTIVE; endproperty
  a_test_once: assert property (p_test_once) else $error("display test restarted");
  property p_test_led; O_TEST_ACTIVE |-> O_INDICATOR_LED == 5'h00; endproperty
  a_test_led: assert property (p_test_led) else $error("led lit in test");
  property p_test_seg;
    O_TEST_ACTIVE |-> $onehot0(O_SEGMENTS[31:24]) && $onehot0(O_SEGMENTS[23:16])
      && $onehot0(O_SEGMENTS[15:8]) && $onehot0(O_SEGMENTS[7:0]);
  endproperty
  a_test_seg: assert property (p_test_seg) else $error("test lit two segments");
  property p_one_led; $onehot0(O_INDICATOR_LED); endproperty
  a_one_led: assert property (p_one_led) else $error("two value leds lit");
endmodule // panel_properties

bind front_panel_menu_controller panel_properties u_props (
  .I_CLOCK(I_CLOCK), .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_SEGMENTS(O_SEGMENTS),
  .O_INDICATOR_LED(O_INDICATOR_LED), .O_ACTIVE_STACK(O_ACTIVE_STACK),
  .O_SWITCHGROUP(O_SWITCHGROUP), .O_TEST_ACTIVE(O_TEST_ACTIVE));
